//--- src/tdi_control.v
// The implementer's own choice: register access over APB.
`default_nettype none
`include "tdi_regs.vh"
module tdi_control #(
  parameter CW = 8                       // Transaction counter width
) (
  input  wire          sys_clk,          // System clock, 200 MHz
  input  wire          resetn,           // Async reset, active low
  input  wire          psel,             // APB select
  input  wire          penable,          // APB enable
  input  wire          pwrite,           // APB direction
  input  wire [11:0]   paddr,            // APB byte address
  input  wire [31:0]   pwdata,           // APB write data
  output reg  [31:0]   prdata,           // APB read data
  output reg           pready,           // APB ready
  output reg           pslverr,          // APB error on unmapped address
  input  wire [7:0]    statusOne,        // Status one from protocol engine
  input  wire [7:0]    statusTwo,        // Status two from protocol engine
  input  wire          errEvent,         // Error condition event
  input  wire          rxEvent,          // Data received event
  input  wire          txEvent,          // Ready to transmit event
  input  wire          rxLoad,           // Load rx block length
  input  wire          txLoad,           // Load tx block length
  input  wire [CW-1:0] blockLen,         // Block length to load
  input  wire          rxDmaAck,         // Rx byte moved by DMA
  input  wire          txDmaAck,         // Tx byte moved by DMA
  output reg           rxDmaReq,         // Rx DMA request
  output reg           txDmaReq,         // Tx DMA request
  output reg           rxRegFileMode,    // Rx DMA to register file
  output reg           txRegFileMode,    // Tx DMA from register file
  output reg  [6:0]    rxPtrLocation,    // Rx DMA pointer location
  output reg  [6:0]    rxCountLocation,  // Rx counter or pair location
  output reg  [6:0]    txPtrLocation,    // Tx DMA pointer location
  output reg  [6:0]    txCountLocation,  // Tx counter or pair location
  output reg           rxUseDmaSegment,  // Rx extension from DMA segment
  output reg           txUseDmaSegment,  // Tx extension from DMA segment
  output reg  [8:0]    sclDivider,       // Full 9-bit SCL divider
  output reg           interfaceEnable,  // Interface enable
  output reg           errIrq,           // Error interrupt request
  output reg           rxIrq,            // Rx interrupt request
  output reg           txIrq,            // Tx interrupt request
  output reg           rxNextByte,       // Start next rx byte
  output reg           txNextByte        // Start next tx byte
);
  reg  [7:0] busControl_reg;
  reg  [7:0] clockSetting_reg;
  reg  [7:0] ownAddrLow_reg;
  reg  [7:0] ownAddrHigh_reg;
  reg  [7:0] dataByte_reg;
  reg  [7:0] genCall_reg;
  reg  [7:0] intStatus_reg;
  reg  [7:0] intVector_reg;
  reg  [7:0] rxAddrPtr_reg;
  reg  [7:0] rxCountPtr_reg;
  reg  [7:0] txAddrPtr_reg;
  reg  [7:0] txCountPtr_reg;
  reg  [7:0] divExt_reg;
  reg  [7:0] intMask_reg;
  reg  [7:0] rdData_next;
  reg        hit_next;
  wire       setupPhase;
  wire       wrAccess;
  wire [7:0] wByte;
  wire [7:0] regAddr;
  wire       inWindow;
  wire       wrIntMask;
  wire       rxDoneFlag;
  wire       txDoneFlag;
  wire       rxDmaReqW;
  wire       txDmaReqW;
  wire       rxBlockEnd;
  wire       txBlockEnd;
  wire       rxNextW;
  wire       txNextW;
  wire       errBlock;
  wire [CW-1:0] rxCount;
  wire [CW-1:0] txCount;

  // No wait state: answer in the cycle after setup, so writes land once
  assign setupPhase = psel && !penable;
  assign wrAccess   = psel && penable && pready && pwrite && inWindow;
  assign wByte      = pwdata[7:0];
  assign regAddr    = paddr[9:2];
  assign inWindow   = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
  assign wrIntMask  = wrAccess && (regAddr == `TDI_OFF_INT_MASK);

  // Suspended mode (select bit 0) lets a pending error hold off DMA
  assign errBlock = !intStatus_reg[`TDI_BIT_SUSPEND_SEL]
                    && intStatus_reg[`TDI_BIT_ERR_PEND];

  // Read mux; registers live at word index equal to the byte offset
  always @* begin
    rdData_next = `TDI_RST_ZERO;
    hit_next    = inWindow;
    if (regAddr == `TDI_OFF_BUS_CONTROL) begin
      rdData_next = busControl_reg;
    end else if (regAddr == `TDI_OFF_STATUS_ONE) begin
      rdData_next = statusOne;
    end else if (regAddr == `TDI_OFF_STATUS_TWO) begin
      rdData_next = statusTwo;
    end else if (regAddr == `TDI_OFF_CLOCK_SETTING) begin
      rdData_next = clockSetting_reg;
    end else if (regAddr == `TDI_OFF_OWN_ADDR_LOW) begin
      rdData_next = ownAddrLow_reg;
    end else if (regAddr == `TDI_OFF_OWN_ADDR_HIGH) begin
      rdData_next = ownAddrHigh_reg;
    end else if (regAddr == `TDI_OFF_DATA_BYTE) begin
      rdData_next = dataByte_reg;
    end else if (regAddr == `TDI_OFF_GEN_CALL_ADDR) begin
      rdData_next = genCall_reg;
    end else if (regAddr == `TDI_OFF_INT_STATUS) begin
      rdData_next = intStatus_reg;
    end else if (regAddr == `TDI_OFF_INT_VECTOR) begin
      rdData_next = intVector_reg;
    end else if (regAddr == `TDI_OFF_RX_ADDR_PTR) begin
      rdData_next = rxAddrPtr_reg;
    end else if (regAddr == `TDI_OFF_RX_COUNT_PTR) begin
      rdData_next = rxCountPtr_reg;
    end else if (regAddr == `TDI_OFF_TX_ADDR_PTR) begin
      rdData_next = txAddrPtr_reg;
    end else if (regAddr == `TDI_OFF_TX_COUNT_PTR) begin
      rdData_next = txCountPtr_reg;
    end else if (regAddr == `TDI_OFF_DIV_EXT) begin
      rdData_next = divExt_reg;
    end else if (regAddr == `TDI_OFF_INT_MASK) begin
      rdData_next = {intMask_reg[7:6], rxDoneFlag, txDoneFlag, intMask_reg[3:0]};
    end else begin
      hit_next = 1'b0;
    end
    if (!inWindow) begin
      hit_next = 1'b0;
    end
  end

  // APB answer: pready one cycle after setup, data and error with it
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase && !hit_next;
      if (setupPhase && !pwrite) begin
        prdata <= {24'h000000, rdData_next};
      end
    end
  end

  // Plain read/write registers, reset to documented values
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busControl_reg   <= `TDI_RST_ZERO;
      clockSetting_reg <= `TDI_RST_ZERO;
      ownAddrLow_reg   <= `TDI_RST_ZERO;
      ownAddrHigh_reg  <= `TDI_RST_ZERO;
      dataByte_reg     <= `TDI_RST_ZERO;
      genCall_reg      <= `TDI_RST_GEN_CALL;
      intVector_reg    <= `TDI_RST_ZERO;
      rxAddrPtr_reg    <= `TDI_RST_ZERO;
      rxCountPtr_reg   <= `TDI_RST_ZERO;
      txAddrPtr_reg    <= `TDI_RST_ZERO;
      txCountPtr_reg   <= `TDI_RST_ZERO;
      divExt_reg       <= `TDI_RST_ZERO;
    end else if (wrAccess) begin
      if (regAddr == `TDI_OFF_BUS_CONTROL) begin
        busControl_reg <= wByte;
      end else if (regAddr == `TDI_OFF_CLOCK_SETTING) begin
        clockSetting_reg <= wByte;
      end else if (regAddr == `TDI_OFF_OWN_ADDR_LOW) begin
        ownAddrLow_reg <= wByte;
      end else if (regAddr == `TDI_OFF_OWN_ADDR_HIGH) begin
        ownAddrHigh_reg <= wByte;
      end else if (regAddr == `TDI_OFF_DATA_BYTE) begin
        dataByte_reg <= wByte;
      end else if (regAddr == `TDI_OFF_GEN_CALL_ADDR) begin
        genCall_reg <= wByte;
      end else if (regAddr == `TDI_OFF_INT_VECTOR) begin
        intVector_reg <= {wByte[7:3], 3'b000};
      end else if (regAddr == `TDI_OFF_RX_ADDR_PTR) begin
        rxAddrPtr_reg <= wByte;
      end else if (regAddr == `TDI_OFF_RX_COUNT_PTR) begin
        rxCountPtr_reg <= wByte;
      end else if (regAddr == `TDI_OFF_TX_ADDR_PTR) begin
        txAddrPtr_reg <= wByte;
      end else if (regAddr == `TDI_OFF_TX_COUNT_PTR) begin
        txCountPtr_reg <= wByte;
      end else if (regAddr == `TDI_OFF_DIV_EXT) begin
        // Reserved bits forced to zero; enable bit never touches this
        divExt_reg <= wByte & `TDI_DIV_EXT_MASK;
      end
    end
  end

  // Interrupt status: control bits written, pending bits set by events,
  // written zero clears, set wins, writing one has no effect
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      intStatus_reg <= `TDI_RST_INT_STATUS;
    end else begin
      if (wrAccess && regAddr == `TDI_OFF_INT_STATUS) begin
        intStatus_reg[7:4] <= wByte[7:4];
        intStatus_reg[`TDI_BIT_ERR_PEND] <= intStatus_reg[`TDI_BIT_ERR_PEND]
                                            & wByte[`TDI_BIT_ERR_PEND];
        intStatus_reg[`TDI_BIT_RX_PEND]  <= intStatus_reg[`TDI_BIT_RX_PEND]
                                            & wByte[`TDI_BIT_RX_PEND];
        intStatus_reg[`TDI_BIT_TX_PEND]  <= intStatus_reg[`TDI_BIT_TX_PEND]
                                            & wByte[`TDI_BIT_TX_PEND];
      end
      if (errEvent) begin
        intStatus_reg[`TDI_BIT_ERR_PEND] <= 1'b1;
      end
      if (rxEvent) begin
        intStatus_reg[`TDI_BIT_RX_PEND] <= 1'b1;
      end
      if (txEvent) begin
        intStatus_reg[`TDI_BIT_TX_PEND] <= 1'b1;
      end
    end
  end

  // Mask register; DMA enables drop at block end, which beats a write
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      intMask_reg <= `TDI_RST_ZERO;
    end else begin
      if (wrIntMask) begin
        intMask_reg <= wByte & `TDI_INT_MASK_WMASK;
      end
      if (rxBlockEnd) begin
        intMask_reg[`TDI_BIT_RX_DMA_EN] <= 1'b0;
      end
      if (txBlockEnd) begin
        intMask_reg[`TDI_BIT_TX_DMA_EN] <= 1'b0;
      end
    end
  end

  // Receive end-of-block flag
  tdi_done_flag uRxDone (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .setPulse (rxBlockEnd),
    .wrStrobe (wrIntMask),
    .wrBit    (wByte[`TDI_BIT_RX_DONE]),
    .flag_reg (rxDoneFlag)
  );

  // Transmit end-of-block flag
  tdi_done_flag uTxDone (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .setPulse (txBlockEnd),
    .wrStrobe (wrIntMask),
    .wrBit    (wByte[`TDI_BIT_TX_DONE]),
    .flag_reg (txDoneFlag)
  );

  // Receive channel; of the mask bits only the rx DMA enable is fed in
  tdi_dma_channel #(.CW(CW)) uRxChan (
    .sys_clk      (sys_clk),
    .resetn       (resetn),
    .loadCount    (rxLoad),
    .countIn      (blockLen),
    .dmaEnable    (intMask_reg[`TDI_BIT_RX_DMA_EN]),
    .dataReq      (intStatus_reg[`TDI_BIT_RX_PEND]),
    .errBlock     (errBlock),
    .dmaAck       (rxDmaAck),
    .dmaReq_reg   (rxDmaReqW),
    .blockEnd_reg (rxBlockEnd),
    .nextByte_reg (rxNextW),
    .count_reg    (rxCount)
  );

  // Transmit channel
  tdi_dma_channel #(.CW(CW)) uTxChan (
    .sys_clk      (sys_clk),
    .resetn       (resetn),
    .loadCount    (txLoad),
    .countIn      (blockLen),
    .dmaEnable    (intMask_reg[`TDI_BIT_TX_DMA_EN]),
    .dataReq      (intStatus_reg[`TDI_BIT_TX_PEND]),
    .errBlock     (errBlock),
    .dmaAck       (txDmaAck),
    .dmaReq_reg   (txDmaReqW),
    .blockEnd_reg (txBlockEnd),
    .nextByte_reg (txNextW),
    .count_reg    (txCount)
  );

  // Registered outputs: pointer decode, divider, interrupt gating
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rxDmaReq        <= 1'b0;
      txDmaReq        <= 1'b0;
      rxRegFileMode   <= 1'b0;
      txRegFileMode   <= 1'b0;
      rxPtrLocation   <= 7'h00;
      rxCountLocation <= 7'h00;
      txPtrLocation   <= 7'h00;
      txCountLocation <= 7'h00;
      rxUseDmaSegment <= 1'b0;
      txUseDmaSegment <= 1'b0;
      sclDivider      <= 9'h000;
      interfaceEnable <= 1'b0;
      errIrq          <= 1'b0;
      rxIrq           <= 1'b0;
      txIrq           <= 1'b0;
      rxNextByte      <= 1'b0;
      txNextByte      <= 1'b0;
    end else begin
      rxDmaReq        <= rxDmaReqW;
      txDmaReq        <= txDmaReqW;
      rxRegFileMode   <= rxCountPtr_reg[`TDI_BIT_MODE_SEL];
      txRegFileMode   <= txCountPtr_reg[`TDI_BIT_MODE_SEL];
      rxPtrLocation   <= rxAddrPtr_reg[7:1];
      rxCountLocation <= rxCountPtr_reg[7:1];
      txPtrLocation   <= txAddrPtr_reg[7:1];
      txCountLocation <= txCountPtr_reg[7:1];
      // Extension select only meaningful in memory mode
      rxUseDmaSegment <= rxAddrPtr_reg[0] && !rxCountPtr_reg[0];
      txUseDmaSegment <= txAddrPtr_reg[0] && !txCountPtr_reg[0];
      sclDivider      <= {divExt_reg[1:0], clockSetting_reg[6:0]};
      interfaceEnable <= busControl_reg[`TDI_BIT_IFACE_EN];
      errIrq          <= intStatus_reg[`TDI_BIT_ERR_PEND]
                         && intMask_reg[`TDI_BIT_ERR_IRQ_EN];
      rxIrq           <= (intStatus_reg[`TDI_BIT_RX_PEND] || rxDoneFlag)
                         && intMask_reg[`TDI_BIT_RX_IRQ_EN];
      txIrq           <= (intStatus_reg[`TDI_BIT_TX_PEND] || txDoneFlag)
                         && intMask_reg[`TDI_BIT_TX_IRQ_EN];
      rxNextByte      <= rxNextW;
      txNextByte      <= txNextW;
    end
  end
endmodule
`default_nettype wire

//--- src/tdi_regs.vh
// Register map, field positions and reset values of the two-wire DMA and interrupt control block
`ifndef TDI_REGS_VH
`define TDI_REGS_VH
`define TDI_OFF_BUS_CONTROL   8'hF0
`define TDI_OFF_STATUS_ONE    8'hF1
`define TDI_OFF_STATUS_TWO    8'hF2
`define TDI_OFF_CLOCK_SETTING 8'hF3
`define TDI_OFF_OWN_ADDR_LOW  8'hF4
`define TDI_OFF_OWN_ADDR_HIGH 8'hF5
`define TDI_OFF_DATA_BYTE     8'hF6
`define TDI_OFF_GEN_CALL_ADDR 8'hF7
`define TDI_OFF_INT_STATUS    8'hF8
`define TDI_OFF_INT_VECTOR    8'hF9
`define TDI_OFF_RX_ADDR_PTR   8'hFA
`define TDI_OFF_RX_COUNT_PTR  8'hFB
`define TDI_OFF_TX_ADDR_PTR   8'hFC
`define TDI_OFF_TX_COUNT_PTR  8'hFD
`define TDI_OFF_DIV_EXT       8'hFE
`define TDI_OFF_INT_MASK      8'hFF
`define TDI_RST_ZERO          8'h00
`define TDI_RST_GEN_CALL      8'hA0
`define TDI_RST_INT_STATUS    8'h80
`define TDI_BIT_IFACE_EN      5
`define TDI_BIT_SUSPEND_SEL   7
`define TDI_BIT_ERR_PEND      2
`define TDI_BIT_RX_PEND       1
`define TDI_BIT_TX_PEND       0
`define TDI_BIT_RX_DMA_EN     7
`define TDI_BIT_TX_DMA_EN     6
`define TDI_BIT_RX_DONE       5
`define TDI_BIT_TX_DONE       4
`define TDI_BIT_ERR_IRQ_EN    2
`define TDI_BIT_RX_IRQ_EN     1
`define TDI_BIT_TX_IRQ_EN     0
`define TDI_BIT_MODE_SEL      0
`define TDI_DIV_EXT_MASK      8'h03
`define TDI_INT_MASK_WMASK    8'hF7
`define TDI_INT_STAT_WMASK    8'hF0
`endif

//--- src/tdi_done_flag.v
// One end-of-block pending flag: set by hardware, cleared only by a written zero
`default_nettype none
module tdi_done_flag (
  input  wire sys_clk,   // System clock
  input  wire resetn,    // Async reset, active low
  input  wire setPulse,  // Block end event
  input  wire wrStrobe,  // Register write this cycle
  input  wire wrBit,     // Written value of the flag bit
  output reg  flag_reg   // Pending flag
);
  // Set wins over a clear in the same cycle; a written one is ignored
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flag_reg <= 1'b0;
    end else if (setPulse) begin
      flag_reg <= 1'b1;
    end else if (wrStrobe && !wrBit) begin
      flag_reg <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- src/tdi_dma_channel.v
// One DMA direction: transaction counter, request gating and block end
`default_nettype none
module tdi_dma_channel #(
  parameter CW = 8                  // Transaction counter width
) (
  input  wire          sys_clk,     // System clock
  input  wire          resetn,      // Async reset, active low
  input  wire          loadCount,   // Load a new block length
  input  wire [CW-1:0] countIn,     // Block length
  input  wire          dmaEnable,   // Channel DMA enable
  input  wire          dataReq,     // Byte wants moving
  input  wire          errBlock,    // Suspend requests (error pending)
  input  wire          dmaAck,      // DMA controller moved one byte
  output reg           dmaReq_reg,  // Request to DMA controller
  output reg           blockEnd_reg,// One-cycle block end pulse
  output reg           nextByte_reg,// Start next byte pulse
  output reg  [CW-1:0] count_reg    // Remaining bytes
);
  wire lastByte;
  assign lastByte = (count_reg == {{(CW-1){1'b0}}, 1'b1});
  // Count down per acked byte; end of block when it hits zero
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count_reg    <= {CW{1'b0}};
      dmaReq_reg   <= 1'b0;
      blockEnd_reg <= 1'b0;
      nextByte_reg <= 1'b0;
    end else begin
      dmaReq_reg   <= dmaEnable && dataReq && !errBlock && !dmaAck;
      blockEnd_reg <= 1'b0;
      nextByte_reg <= 1'b0;
      if (loadCount) begin
        count_reg <= countIn;
      end else if (dmaAck && dmaEnable) begin
        count_reg    <= count_reg - {{(CW-1){1'b0}}, 1'b1};
        blockEnd_reg <= lastByte;
        nextByte_reg <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/tdi_checker.sv
// Port-level checks for the two-wire DMA and interrupt control block
`default_nettype none
module tdi_checker (
  input wire logic        sys_clk,         // Clock
  input wire logic        resetn,          // Reset, low
  input wire logic        psel,            // Select
  input wire logic        penable,         // Enable
  input wire logic        pwrite,          // Direction
  input wire logic [11:0] paddr,           // Address
  input wire logic [31:0] pwdata,          // Write data
  input wire logic        pready,          // Ready
  input wire logic        pslverr,         // Error
  input wire logic        txDmaAck,        // Tx moved
  input wire logic        txDmaReq,        // Tx request
  input wire logic        rxRegFileMode,   // Rx mode
  input wire logic        txRegFileMode,   // Tx mode
  input wire logic        rxUseDmaSegment, // Rx ext
  input wire logic        txUseDmaSegment, // Tx ext
  input wire logic [8:0]  sclDivider,      // Divider
  input wire logic        rxNextByte,      // Rx next
  input wire logic        txNextByte       // Tx next
);
  logic setup;
  logic wrAcc;
  // Bus phases; mirrored outputs land two edges after the write edge
  assign setup = psel & ~penable;
  assign wrAcc = psel & penable & pready & pwrite;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  setup_answer_a:
    assert property (setup |=> pready) else $error("no ready after setup");
  misaligned_err_a:
    assert property (setup && paddr[1:0] != 2'b00 |=> pslverr) else $error("no error");
  mapped_ok_a:
    assert property (setup && paddr[11:6] == 6'h0F && paddr[1:0] == 2'b00 |=> !pslverr)
    else $error("error on mapped register");
  div_high_a:
    assert property (wrAcc && paddr == 12'h3F8 |-> ##2 sclDivider[8:7] == $past(pwdata[1:0], 2))
    else $error("divider high bits wrong");
  div_low_a:
    assert property (wrAcc && paddr == 12'h3CC |-> ##2 sclDivider[6:0] == $past(pwdata[6:0], 2))
    else $error("divider low bits wrong");
  rx_mode_a:
    assert property (wrAcc && paddr == 12'h3EC |-> ##2 rxRegFileMode == $past(pwdata[0], 2))
    else $error("rx mode wrong");
  tx_mode_a:
    assert property (wrAcc && paddr == 12'h3F4 |-> ##2 txRegFileMode == $past(pwdata[0], 2))
    else $error("tx mode wrong");
  rx_seg_a:
    assert property (wrAcc && paddr == 12'h3E8 |->
      ##2 rxUseDmaSegment == ($past(pwdata[0], 2) && !rxRegFileMode))
    else $error("rx extension select wrong");
  tx_seg_a:
    assert property (wrAcc && paddr == 12'h3F0 |->
      ##2 txUseDmaSegment == ($past(pwdata[0], 2) && !txRegFileMode))
    else $error("tx extension select wrong");
  tx_next_a:
    assert property (txDmaAck |-> ##2 txNextByte) else $error("no next byte");
  rx_pulse_a:
    assert property (rxNextByte |=> !rxNextByte) else $error("next byte too long");
endmodule
`default_nettype wire

//--- dv/tdi_dma_model.sv
// Behavioural DMA controller channel acknowledging requests after a set delay
`default_nettype none
module tdi_dma_model #(
  parameter int DLY = 0 // Cycles before the ack
) (
  input  wire logic sys_clk, // Clock
  input  wire logic resetn,  // Reset, low
  input  wire logic dmaReq,  // Request
  output var logic  dmaAck   // Byte moved
);
  int cnt;
  // Ack a held request; the quiet spell lets the request fall first
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      dmaAck <= 1'b0;
    end else begin
      dmaAck <= dmaReq && cnt == DLY;
      if (cnt < 0 || (dmaReq && cnt < DLY))
        cnt <= cnt + 1;
      else if (dmaReq && cnt == DLY)
        cnt <= -4;
    end
  end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the two-wire DMA and interrupt control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, resetn, psel, penable, pwrite, pready, pslverr, errVal;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdVal;
  logic [7:0]  statusOne, statusTwo, blockLen;
  logic        errEvent, rxEvent, txEvent, rxLoad, txLoad, rxDmaAck, txDmaAck;
  logic        rxDmaReq, txDmaReq, rxRegFileMode, txRegFileMode, interfaceEnable;
  logic        rxUseDmaSegment, txUseDmaSegment, errIrq, rxIrq, txIrq, rxNextByte, txNextByte;
  logic [6:0]  rxPtrLocation, rxCountLocation, txPtrLocation, txCountLocation;
  logic [8:0]  sclDivider;
  int          mismatches = 0, cmpCount = 0, rxAcks = 0, txAcks = 0, a0;
  logic [7:0]  pv [2][4] = '{'{8'h03, 8'h54, 8'hFE, 8'hAB}, '{8'h81, 8'h01, 8'h01, 8'h00}};

  tdi_control #(.CW(8)) uut (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .statusOne, .statusTwo, .errEvent, .rxEvent, .txEvent,
    .rxLoad, .txLoad, .blockLen, .rxDmaAck, .txDmaAck, .rxDmaReq, .txDmaReq, .rxRegFileMode,
    .txRegFileMode, .rxPtrLocation, .rxCountLocation, .txPtrLocation, .txCountLocation,
    .rxUseDmaSegment, .txUseDmaSegment, .sclDivider, .interfaceEnable, .errIrq, .rxIrq,
    .txIrq, .rxNextByte, .txNextByte);
  tdi_dma_model #(.DLY(0)) rxDma (.sys_clk, .resetn, .dmaReq(rxDmaReq), .dmaAck(rxDmaAck));
  tdi_dma_model #(.DLY(6)) txDma (.sys_clk, .resetn, .dmaReq(txDmaReq), .dmaAck(txDmaAck));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Bytes handed over by the DMA models
  always @(posedge sys_clk) begin
    rxAcks <= rxAcks + (rxDmaAck === 1'b1);
    txAcks <= txAcks + (txDmaAck === 1'b1);
  end

  task automatic wrap_up;
    $display("counts: %0d compared, %0d wrong", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One transfer; the idle edge at the end keeps psel from two drives in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
    rdVal = prdata;
    errVal = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    apb(1'b1, {2'b00, off, 2'b00}, d);
  endtask
  task automatic rdc(input logic [7:0] off, input logic [7:0] exp);
    apb(1'b0, {2'b00, off, 2'b00}, 8'h00);
    chk(rdVal, {24'h0, exp});
  endtask
  // Re-raise the event until the model has moved the wanted byte total
  task automatic move(input logic tx, input int n);
    int g;
    for (g = 0; g < 300 && (tx ? txAcks : rxAcks) < n; g++) begin
      txEvent <= tx && g % 10 == 0;
      rxEvent <= !tx && g % 10 == 0;
      @(posedge sys_clk);
    end
    txEvent <= 1'b0;
    rxEvent <= 1'b0;
    if (g == 300) begin
      mismatches++;
      wrap_up();
    end
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic load(input logic tx, input logic [7:0] len);
    blockLen <= len;
    txLoad <= tx;
    rxLoad <= !tx;
    @(posedge sys_clk);
    txLoad <= 1'b0;
    rxLoad <= 1'b0;
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, blockLen} = '0;
    {errEvent, rxEvent, txEvent, rxLoad, txLoad} = '0;
    statusOne = 8'h5A;
    statusTwo = 8'h3C;
    resetn = 1'b0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 16; i++)
      rdc(8'hF0 + 8'(i), i == 1 ? 8'h5A : i == 2 ? 8'h3C : i == 7 ? 8'hA0 :
          i == 8 ? 8'h80 : 8'h00);
    apb(1'b0, 12'h3C1, 8'h00);
    chk(errVal, 1);
    wr(8'hFF, 8'h00);
    // Out-of-window write must be refused and leave the mask alone
    apb(1'b1, 12'hBFC, 8'hFF);
    chk(errVal, 1);
    rdc(8'hFF, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 2; k++) begin
      for (int j = 0; j < 4; j++)
        wr(8'hFA + 8'(j), pv[k][j]);
      @(posedge sys_clk);
      chk(rxPtrLocation, pv[k][0][7:1]);
      chk(rxUseDmaSegment, pv[k][0][0] & ~pv[k][1][0]);
      chk(rxCountLocation, pv[k][1][7:1]);
      chk(rxRegFileMode, pv[k][1][0]);
      chk(txPtrLocation, pv[k][2][7:1]);
      chk(txUseDmaSegment, pv[k][2][0] & ~pv[k][3][0]);
      chk(txCountLocation, pv[k][3][7:1]);
      chk(txRegFileMode, pv[k][3][0]);
      rdc(8'hFD, pv[k][3]);
    end
    $display("test pointers done");
    wr(8'hF3, 8'hA5);
    wr(8'hFE, 8'hFF);
    wr(8'hF0, 8'h20);
    rdc(8'hFE, 8'h03);
    chk(sclDivider, 9'h1A5);
    chk(interfaceEnable, 1);
    wr(8'hF0, 8'h00);
    rdc(8'hFE, 8'h03);
    chk(sclDivider, 9'h1A5);
    chk(interfaceEnable, 0);
    wr(8'hFF, 8'h3F);
    rdc(8'hFF, 8'h07);
    $display("test divider done");
    load(1'b1, 8'h02);
    wr(8'hFF, 8'h41);
    a0 = txAcks;
    move(1'b1, a0 + 2);
    rdc(8'hFF, 8'h11);
    chk(txIrq, 1);
    wr(8'hFF, 8'h10);
    rdc(8'hFF, 8'h10);
    chk(txIrq, 0);
    load(1'b0, 8'h01);
    wr(8'hFF, 8'h80);
    a0 = rxAcks;
    move(1'b0, a0 + 1);
    rdc(8'hFF, 8'h20);
    chk(rxIrq, 0);
    wr(8'hFF, 8'h22);
    @(posedge sys_clk);
    chk(rxIrq, 1);
    wr(8'hF8, 8'h80);
    wr(8'hFF, 8'h02);
    rdc(8'hFF, 8'h02);
    chk(rxIrq, 0);
    $display("test blocks done");
    wr(8'hF8, 8'h00);
    wr(8'hFF, 8'h04);
    errEvent <= 1'b1;
    @(posedge sys_clk);
    errEvent <= 1'b0;
    rdc(8'hF8, 8'h04);
    chk(errIrq, 1);
    load(1'b1, 8'h01);
    wr(8'hFF, 8'h40);
    a0 = txAcks;
    txEvent <= 1'b1;
    @(posedge sys_clk);
    txEvent <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk(txAcks, a0);
    chk(errIrq, 0);
    wr(8'hF8, 8'h00);
    move(1'b1, a0 + 1);
    rdc(8'hFF, 8'h10);
    // Not-suspended mode: a pending error must not hold off DMA
    wr(8'hF8, 8'h80);
    errEvent <= 1'b1;
    load(1'b1, 8'h01);
    errEvent <= 1'b0;
    wr(8'hFF, 8'h40);
    a0 = txAcks;
    move(1'b1, a0 + 1);
    rdc(8'hF8, 8'h85);
    $display("test suspend done");
    wrap_up();
  end
endmodule

bind tdi_control tdi_checker chk_i (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .txDmaAck, .txDmaReq, .rxRegFileMode, .txRegFileMode,
  .rxUseDmaSegment, .txUseDmaSegment, .sclDivider, .rxNextByte, .txNextByte);
`default_nettype wire
